/* dv/tccu_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far-side signal source on the channel pin
module tccu_pin_model (
    // clock
    input wire logic mclk_i,
    // command from the bench
    input wire logic go_i,
    input wire logic [4:0] n_edges_i,
    output logic done_o,
    // pin level offered to the wire
    output logic pin_o
);
    int left;
    int ph;

    initial begin
        pin_o = 1'b0;
        done_o = 1'b1;
        left = 0;
        ph = 0;
    end

    // pulses are three clocks high and three low, long enough for the
    // three-stage synchroniser on the device side to see every edge
    always @(posedge mclk_i) begin
        if (go_i) begin
            left <= n_edges_i;
            ph <= 0;
            done_o <= 1'b0;
        end else if (left > 0) begin
            ph <= (ph == 5) ? 0 : ph + 1;
            pin_o <= (ph < 3);
            if (ph == 5) begin
                left <= left - 1;
            end
        end else begin
            pin_o <= 1'b0;
            done_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* dv/timer_capture_compare_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench for the timer capture compare unit
module timer_capture_compare_unit_tb;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sleep_i = 1'b0;
    logic adc_enable_i = 1'b1;
    logic ext_clk_i = 1'b0;
    logic go = 1'b0;
    logic [4:0] n_edges = 5'h00;
    wire logic [7:0] rdata_o;
    wire logic irq_o, wake_o, wake_vector_o, adc_start_o;
    wire logic ccp_pin_o, ccp_pin_oe_b_o, model_pin, model_done, pin_w;
    wire logic [15:0] vector_o;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int wake_n = 0;
    int vec_n = 0;
    int adc_n = 0;
    logic [7:0] d, h;
    int w0, v0;
    logic [3:0] r_mode [8] = '{4'h4, 4'h5, 4'h6, 4'h6, 4'h7, 4'h7, 4'h2, 4'h0};
    logic [4:0] r_edges [8] = '{1, 1, 3, 4, 15, 16, 4, 4};
    logic r_flag [8] = '{1, 1, 0, 1, 0, 1, 0, 0};
    logic [3:0] c_mode [4] = '{4'h8, 4'ha, 4'h9, 4'hb};
    logic c_pin [4] = '{1, 1, 0, 0};

    always #10 mclk_i = ~mclk_i;

    // the wire: the device wins only while its active-low enable is low
    assign pin_w = ccp_pin_oe_b_o ? model_pin : ccp_pin_o;

    tccu_timer_capture_compare tccu_timer_capture_compare_inst (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sleep_i(sleep_i), .adc_enable_i(adc_enable_i),
        .ext_clk_i(ext_clk_i), .irq_o(irq_o), .wake_o(wake_o),
        .wake_vector_o(wake_vector_o), .vector_o(vector_o),
        .adc_start_o(adc_start_o), .ccp_pin_i(pin_w),
        .ccp_pin_o(ccp_pin_o), .ccp_pin_oe_b_o(ccp_pin_oe_b_o)
    );

    tccu_pin_model tccu_pin_model_inst (
        .mclk_i(mclk_i), .go_i(go), .n_edges_i(n_edges),
        .done_o(model_done), .pin_o(model_pin)
    );

    // ======================================================
    // event tallies and hang guard
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (wake_o === 1'b1) wake_n <= wake_n + 1;
        if (wake_vector_o === 1'b1) vec_n <= vec_n + 1;
        if (adc_start_o === 1'b1) adc_n <= adc_n + 1;
        if (cyc == 30000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // ======================================================
    // register port; a gap cycle between calls keeps strobes clean
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    task automatic pulses(input logic [4:0] n);
        @(posedge mclk_i);
        go <= 1'b1;
        n_edges <= n;
        @(posedge mclk_i);
        go <= 1'b0;
        // the model lowers done at the go edge; wait until that has landed
        @(posedge mclk_i);
        for (int k = 0; k < 300 && model_done !== 1'b1; k++) begin
            @(posedge mclk_i);
        end
        repeat (6) @(posedge mclk_i);
    endtask

    // ======================================================
    // main sequence
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        chk(ccp_pin_oe_b_o, 1'b1);
        chk(vector_o, 16'h0004);
        rd(tccu_pkg::ADDR_CTL, d);
        chk(d, 8'h00);
        wr(tccu_pkg::ADDR_CTL, 8'hff);
        rd(tccu_pkg::ADDR_CTL, d);
        chk(d, 8'h3f);
        wr(4'hf, 8'h5a);
        rd(4'hf, d);
        chk(d, 8'h00);
        // capture rows: timer held still so the copied count is known
        for (int i = 0; i < 8; i++) begin
            wr(tccu_pkg::ADDR_CTL, tccu_pkg::MODE_OFF);
            wr(tccu_pkg::ADDR_FLAGS, 8'h00);
            wr(tccu_pkg::ADDR_TB_LOW, 8'h40 + i[7:0]);
            wr(tccu_pkg::ADDR_TB_HIGH, 8'h12);
            wr(tccu_pkg::ADDR_CTL, {4'h0, r_mode[i]});
            pulses(r_edges[i]);
            rd(tccu_pkg::ADDR_FLAGS, d);
            chk(d[tccu_pkg::FLG_CH], r_flag[i]);
            if (r_flag[i]) begin
                rd(tccu_pkg::ADDR_CC_LOW, d);
                rd(tccu_pkg::ADDR_CC_HIGH, h);
                chk({h, d}, {8'h12, 8'h40 + i[7:0]});
            end
        end
        wr(tccu_pkg::ADDR_CTL, tccu_pkg::MODE_OFF);
        // overflow: flag cleared and counter loaded with fffe before enabling
        wr(tccu_pkg::ADDR_FLAGS, 8'h00);
        wr(tccu_pkg::ADDR_TB_LOW, 8'hfe);
        wr(tccu_pkg::ADDR_TB_HIGH, 8'hff);
        wr(tccu_pkg::ADDR_ENABLES, 8'h01);
        wr(tccu_pkg::ADDR_INT_CTL, 8'h80);
        wr(tccu_pkg::ADDR_TB_CTL, 8'h01);
        repeat (8) @(posedge mclk_i);
        rd(tccu_pkg::ADDR_FLAGS, d);
        chk(d[tccu_pkg::FLG_OVF], 1'b1);
        chk(irq_o, 1'b0);
        wr(tccu_pkg::ADDR_INT_CTL, 8'hc0);
        repeat (2) @(posedge mclk_i);
        chk(irq_o, 1'b1);
        wr(tccu_pkg::ADDR_FLAGS, 8'h00);
        repeat (2) @(posedge mclk_i);
        chk(irq_o, 1'b0);
        // sleep: synchronous counting must halt
        wr(tccu_pkg::ADDR_TB_CTL, 8'h00);
        wr(tccu_pkg::ADDR_TB_LOW, 8'hff);
        wr(tccu_pkg::ADDR_TB_HIGH, 8'hff);
        sleep_i <= 1'b1;
        wr(tccu_pkg::ADDR_TB_CTL, 8'h01);
        repeat (10) @(posedge mclk_i);
        rd(tccu_pkg::ADDR_TB_LOW, d);
        chk(d, 8'hff);
        chk(wake_n, 0);
        // asynchronous counting wakes and branches
        w0 = wake_n;
        v0 = vec_n;
        wr(tccu_pkg::ADDR_TB_CTL, 8'h03);
        repeat (3) begin
            repeat (3) @(posedge mclk_i);
            ext_clk_i <= 1'b1;
            repeat (3) @(posedge mclk_i);
            ext_clk_i <= 1'b0;
        end
        repeat (6) @(posedge mclk_i);
        chk(wake_n - w0, 1);
        chk(vec_n - v0, 1);
        sleep_i <= 1'b0;
        wr(tccu_pkg::ADDR_TB_CTL, 8'h00);
        wr(tccu_pkg::ADDR_INT_CTL, 8'h00);
        // compare: order chosen so an untouched pin shows a stale level
        for (int i = 0; i < 4; i++) begin
            wr(tccu_pkg::ADDR_TB_LOW, 8'h00);
            wr(tccu_pkg::ADDR_TB_HIGH, 8'h00);
            wr(tccu_pkg::ADDR_CC_LOW, 8'h20);
            wr(tccu_pkg::ADDR_CC_HIGH, 8'h00);
            wr(tccu_pkg::ADDR_FLAGS, 8'h00);
            wr(tccu_pkg::ADDR_CTL, {4'h0, c_mode[i]});
            w0 = adc_n;
            wr(tccu_pkg::ADDR_TB_CTL, 8'h01);
            repeat (48) @(posedge mclk_i);
            wr(tccu_pkg::ADDR_TB_CTL, 8'h00);
            chk(ccp_pin_o, c_pin[i]);
            rd(tccu_pkg::ADDR_FLAGS, d);
            chk(d, 8'h02);
            if (i == 0) chk(ccp_pin_oe_b_o, 1'b0);
            rd(tccu_pkg::ADDR_TB_HIGH, h);
            rd(tccu_pkg::ADDR_TB_LOW, d);
            chk(adc_n - w0, (i == 3) ? 1 : 0);
            chk({h, d} < 16'h0020, i == 3);
        end
        // pwm: full duty keeps the pin high, zero duty keeps it low
        wr(tccu_pkg::ADDR_DUTY_HI, 8'hff);
        wr(tccu_pkg::ADDR_CTL, 8'h3c);
        repeat (4) @(posedge mclk_i);
        chk(ccp_pin_o, 1'b1);
        chk(ccp_pin_oe_b_o, 1'b0);
        wr(tccu_pkg::ADDR_DUTY_HI, 8'h00);
        wr(tccu_pkg::ADDR_CTL, 8'h0c);
        repeat (4) @(posedge mclk_i);
        chk(ccp_pin_o, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire

/* hdl/tccu_timer_capture_compare.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - time base counts up to ffff, wraps to 0000, sets overflow flag on wrap.
// - overflow interrupt needs overflow enable, peripheral enable and global enable.
// - during sleep the time base counts only in asynchronous external mode.
// - running overflow with both enables wakes; branches to vector if global enabled.
// - capture copies the 16-bit count into the value pair on the chosen event.
// - compare fires the chosen action when value pair equals the count.
// - special event clears counter without overflow flag; channel flag still set.
// - counter byte write in the same cycle as special event wins over clear.
// - capture and compare use 16-bit time base, PWM uses 8-bit period timer.
// - mode zero switches channel off and resets its internal state.
// - modes one to three are reserved and do nothing.
// - modes 4-7 capture on falling, rising, 4th rising, 16th rising edge.
// - mode 8 sets pin, mode 9 clears pin on match; both set channel flag.
// - mode 10 only sets channel flag on match, pin unchanged.
// - mode 11 sets flag, resets counter, starts conversion if enabled.
module tccu_timer_capture_compare (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // system side
    input wire logic sleep_i,
    input wire logic adc_enable_i,
    input wire logic ext_clk_i,
    output logic irq_o,
    output logic wake_o,
    output logic wake_vector_o,
    output logic [15:0] vector_o,
    output logic adc_start_o,
    // channel pin
    input wire logic ccp_pin_i,
    output logic ccp_pin_o,
    output logic ccp_pin_oe_b_o
);
    // ======================================================
    // state
    typedef struct packed {
        logic [15:0] tb_cnt;
        logic [15:0] cc_val;
        logic [7:0] ctl;
        logic tb_run;
        logic tb_async;
        logic ovf_flag;
        logic ch_flag;
        logic ovf_ie;
        logic ch_ie;
        logic peripheral_interrupt_enable;
        logic global_interrupt_enable;
        logic [7:0] duty_hi;
        logic [7:0] pwm_tmr;
        logic [2:0] pin_sync;
        logic [2:0] ext_sync;
        logic [3:0] presc;
        logic eq_q;
        logic pin_out;
        logic pin_oe_b;
        logic [7:0] rdata;
        logic irq;
        logic wake;
        logic wake_vec;
        logic adc_start;
    } tccu_state_s;

    tccu_state_s st;
    tccu_state_s next_st;

    // ======================================================
    // helpers
    // capture event from the synchronised pin and prescaler
    function automatic logic f_cap_hit(input logic [3:0] mode,
                                       input logic rise,
                                       input logic fall,
                                       input logic [3:0] presc);
        unique case (mode)
            tccu_pkg::MODE_CAP_FALL: f_cap_hit = fall;
            tccu_pkg::MODE_CAP_RISE: f_cap_hit = rise;
            tccu_pkg::MODE_CAP_RISE4:
                f_cap_hit = rise && presc == tccu_pkg::PRE_DIV4_LAST;
            tccu_pkg::MODE_CAP_RISE16:
                f_cap_hit = rise && presc == tccu_pkg::PRE_DIV16_LAST;
            default: f_cap_hit = 1'b0;
        endcase
    endfunction

    function automatic logic f_is_cmp(input logic [3:0] mode);
        f_is_cmp = mode[3:2] == 2'b10;
    endfunction

    logic [3:0] mode;
    logic [3:0] next_mode;
    logic rise;
    logic fall;
    logic ext_edge;
    logic tb_inc;
    logic cap_hit;
    logic cmp_fire;
    logic sev_fire;
    logic tb_wr;
    logic wr_ctl;

    assign mode = st.ctl[3:0];
    assign next_mode = wdata_i[3:0];
    // only stages two and three are looked at; stage one is metastable
    assign rise = st.pin_sync[1] && !st.pin_sync[2];
    assign fall = !st.pin_sync[1] && st.pin_sync[2];
    assign ext_edge = st.ext_sync[1] && !st.ext_sync[2];
    assign wr_ctl = wr_i && addr_i == tccu_pkg::ADDR_CTL;
    assign tb_wr = wr_i && (addr_i == tccu_pkg::ADDR_TB_LOW ||
                            addr_i == tccu_pkg::ADDR_TB_HIGH);
    // synchronous mode stops in sleep, asynchronous mode keeps counting
    assign tb_inc = st.tb_run &&
                    (st.tb_async ? ext_edge : !sleep_i);
    assign cap_hit = f_cap_hit(mode, rise, fall, st.presc);
    // fire once as the count reaches the value, not every cycle it rests
    assign cmp_fire = f_is_cmp(mode) &&
                      st.cc_val == st.tb_cnt && !st.eq_q;
    assign sev_fire = cmp_fire && mode == tccu_pkg::MODE_CMP_SEV;

    // ======================================================
    // next state
    always_comb begin
        logic ovf_set;
        logic ch_set;
        ovf_set = 1'b0;
        ch_set = 1'b0;
        next_st = st;
        next_st.pin_sync = {st.pin_sync[1:0], ccp_pin_i};
        next_st.ext_sync = {st.ext_sync[1:0], ext_clk_i};
        next_st.eq_q = f_is_cmp(mode) && st.cc_val == st.tb_cnt;

        // time base: count, wrap, special event clear, software write
        if (sev_fire) begin
            next_st.tb_cnt = tccu_pkg::TB_ZERO;
        end else if (tb_inc) begin
            next_st.tb_cnt = st.tb_cnt + 16'h0001;
            ovf_set = st.tb_cnt == tccu_pkg::TB_MAX;
        end
        if (wr_i && addr_i == tccu_pkg::ADDR_TB_LOW) begin
            next_st.tb_cnt[7:0] = wdata_i;
        end
        if (wr_i && addr_i == tccu_pkg::ADDR_TB_HIGH) begin
            next_st.tb_cnt[15:8] = wdata_i;
        end

        // capture and capture prescaler
        if (cap_hit) begin
            next_st.cc_val = st.tb_cnt;
            ch_set = 1'b1;
        end
        if ((mode == tccu_pkg::MODE_CAP_RISE4 ||
             mode == tccu_pkg::MODE_CAP_RISE16) && rise) begin
            next_st.presc = cap_hit ? 4'h0 : st.presc + 4'h1;
        end

        // compare actions; reserved codes never reach here
        if (cmp_fire) begin
            ch_set = 1'b1;
            if (mode == tccu_pkg::MODE_CMP_SET) begin
                next_st.pin_out = 1'b1;
            end else if (mode == tccu_pkg::MODE_CMP_CLR) begin
                next_st.pin_out = 1'b0;
            end
        end
        next_st.adc_start = sev_fire && adc_enable_i;

        // pwm on the 8-bit period timer, duty split over two registers
        if (mode[3:2] == 2'b11) begin
            next_st.pwm_tmr = st.pwm_tmr + 8'h01;
            next_st.pin_out = {st.pwm_tmr, 2'b00} <
                {st.duty_hi, st.ctl[5:4]};
        end else begin
            next_st.pwm_tmr = 8'h00;
        end
        // pin is driven in set, clear and pwm modes only
        next_st.pin_oe_b = !(mode == tccu_pkg::MODE_CMP_SET ||
                             mode == tccu_pkg::MODE_CMP_CLR ||
                             mode[3:2] == 2'b11);

        // register writes
        if (wr_i) begin
            unique case (addr_i)
                tccu_pkg::ADDR_CC_LOW: next_st.cc_val[7:0] = wdata_i;
                tccu_pkg::ADDR_CC_HIGH: next_st.cc_val[15:8] = wdata_i;
                tccu_pkg::ADDR_CTL:
                    next_st.ctl = wdata_i & tccu_pkg::CTL_WMASK;
                tccu_pkg::ADDR_TB_CTL: begin
                    next_st.tb_run = wdata_i[tccu_pkg::TBC_RUN];
                    next_st.tb_async = wdata_i[tccu_pkg::TBC_ASYNC];
                end
                tccu_pkg::ADDR_FLAGS: begin
                    next_st.ovf_flag = wdata_i[tccu_pkg::FLG_OVF];
                    next_st.ch_flag = wdata_i[tccu_pkg::FLG_CH];
                end
                tccu_pkg::ADDR_ENABLES: begin
                    next_st.ovf_ie = wdata_i[tccu_pkg::FLG_OVF];
                    next_st.ch_ie = wdata_i[tccu_pkg::FLG_CH];
                end
                tccu_pkg::ADDR_INT_CTL: begin
                    next_st.peripheral_interrupt_enable = wdata_i[tccu_pkg::INT_PERIPHERAL_INTERRUPT_ENABLE];
                    next_st.global_interrupt_enable = wdata_i[tccu_pkg::INT_GIE];
                end
                tccu_pkg::ADDR_DUTY_HI: next_st.duty_hi = wdata_i;
                default: begin
                end
            endcase
        end
        // a new mode restarts the edge prescaler
        if (wr_ctl && next_mode != mode) begin
            next_st.presc = 4'h0;
        end
        // off clears prescaler, pin level, match history and pwm timer; a write leaving it wins
        if (mode == tccu_pkg::MODE_OFF && !wr_ctl) begin
            next_st.presc = 4'h0;
            next_st.pin_out = 1'b0;
            next_st.eq_q = 1'b0;
            next_st.pwm_tmr = 8'h00;
        end

        // hardware set beats a software clear in the same cycle
        if (ovf_set) begin
            next_st.ovf_flag = 1'b1;
        end
        if (ch_set) begin
            next_st.ch_flag = 1'b1;
        end

        // interrupt output follows the next flags; wake outputs pulse on the overflow set itself
        next_st.irq = ((next_st.ovf_flag && next_st.ovf_ie) ||
                       (next_st.ch_flag && next_st.ch_ie)) &&
                      next_st.peripheral_interrupt_enable && next_st.global_interrupt_enable;
        next_st.wake = ovf_set && sleep_i && st.tb_run &&
                       st.ovf_ie && st.peripheral_interrupt_enable;
        next_st.wake_vec = ovf_set && sleep_i && st.tb_run &&
                           st.ovf_ie && st.peripheral_interrupt_enable && st.global_interrupt_enable;

        // read data stands one cycle after the strobe only
        next_st.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                tccu_pkg::ADDR_TB_LOW: next_st.rdata = st.tb_cnt[7:0];
                tccu_pkg::ADDR_TB_HIGH: next_st.rdata = st.tb_cnt[15:8];
                tccu_pkg::ADDR_CC_LOW: next_st.rdata = st.cc_val[7:0];
                tccu_pkg::ADDR_CC_HIGH: next_st.rdata = st.cc_val[15:8];
                tccu_pkg::ADDR_CTL:
                    next_st.rdata = st.ctl & tccu_pkg::CTL_WMASK;
                tccu_pkg::ADDR_TB_CTL:
                    next_st.rdata = {6'h00, st.tb_async, st.tb_run};
                tccu_pkg::ADDR_FLAGS:
                    next_st.rdata = {6'h00, st.ch_flag, st.ovf_flag};
                tccu_pkg::ADDR_ENABLES:
                    next_st.rdata = {6'h00, st.ch_ie, st.ovf_ie};
                tccu_pkg::ADDR_INT_CTL:
                    next_st.rdata = {st.global_interrupt_enable, st.peripheral_interrupt_enable, 6'h00};
                tccu_pkg::ADDR_DUTY_HI: next_st.rdata = st.duty_hi;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // ======================================================
    // state register
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
            st.ctl <= tccu_pkg::CTL_RESET;
            st.pin_oe_b <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign irq_o = st.irq;
    assign wake_o = st.wake;
    assign wake_vector_o = st.wake_vec;
    assign vector_o = tccu_pkg::IRQ_VECTOR;
    assign adc_start_o = st.adc_start;
    assign ccp_pin_o = st.pin_out;
    assign ccp_pin_oe_b_o = st.pin_oe_b;

    // ======================================================
    // assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_wrap;
        tb_inc && st.tb_cnt == tccu_pkg::TB_MAX && !tb_wr && !sev_fire;
    endsequence
    sequence s_wrapped;
        st.tb_cnt == tccu_pkg::TB_ZERO && st.ovf_flag;
    endsequence
    property p_wrap;
        s_wrap |=> s_wrapped;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap failed");

    property p_irq;
        st.ovf_flag && st.ovf_ie && st.peripheral_interrupt_enable && st.global_interrupt_enable |-> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_flag_hold;
        st.ovf_flag && !(wr_i && addr_i == tccu_pkg::ADDR_FLAGS)
            |=> st.ovf_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag dropped");

    property p_sleep;
        sleep_i && !st.tb_async && !tb_wr && !sev_fire
            |=> $stable(st.tb_cnt);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("counted in sleep");

    property p_capture;
        cap_hit && !(wr_i && (addr_i == tccu_pkg::ADDR_CC_LOW ||
                              addr_i == tccu_pkg::ADDR_CC_HIGH))
            |=> st.cc_val == $past(st.tb_cnt) && st.ch_flag;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture wrong");

    sequence s_match(logic [3:0] m);
        cmp_fire && mode == m;
    endsequence
    property p_set_pin;
        s_match(tccu_pkg::MODE_CMP_SET) |=> ccp_pin_o && !ccp_pin_oe_b_o;
    endproperty
    a_set_pin: assert property (p_set_pin)
        else $error("pin not set");

    property p_sev;
        sev_fire && !tb_wr
            |=> st.tb_cnt == tccu_pkg::TB_ZERO &&
                adc_start_o == $past(adc_enable_i) &&
                st.ch_flag && $stable(st.ovf_flag);
    endproperty
    a_sev: assert property (p_sev) else $error("special event");

    property p_sev_write;
        sev_fire && wr_i && addr_i == tccu_pkg::ADDR_TB_LOW
            |=> st.tb_cnt[7:0] == $past(wdata_i);
    endproperty
    a_sev_write: assert property (p_sev_write)
        else $error("write lost");

    property p_off;
        mode == tccu_pkg::MODE_OFF && !wr_ctl
            |=> st.presc == 4'h0 && !ccp_pin_o && ccp_pin_oe_b_o;
    endproperty
    a_off: assert property (p_off) else $error("off not reset");

    property p_reserved;
        mode inside {4'h1, 4'h2, 4'h3} |-> !cmp_fire && !cap_hit;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved acted");

    property p_ctl_read;
        rd_i && addr_i == tccu_pkg::ADDR_CTL |=> rdata_o[7:6] == 2'b00;
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("ctl high bits");
endmodule
`default_nettype wire

/* shared/tccu_pkg.sv */
// ==========================================================
// register map, field layout and mode codes
package tccu_pkg;
    // register indices on the 4-bit byte-wide port
    localparam logic [3:0] ADDR_TB_LOW = 4'h0;
    localparam logic [3:0] ADDR_TB_HIGH = 4'h1;
    localparam logic [3:0] ADDR_CC_LOW = 4'h2;
    localparam logic [3:0] ADDR_CC_HIGH = 4'h3;
    localparam logic [3:0] ADDR_CTL = 4'h4;
    localparam logic [3:0] ADDR_TB_CTL = 4'h5;
    localparam logic [3:0] ADDR_FLAGS = 4'h6;
    localparam logic [3:0] ADDR_ENABLES = 4'h7;
    localparam logic [3:0] ADDR_INT_CTL = 4'h8;
    localparam logic [3:0] ADDR_DUTY_HI = 4'h9;
    // control register fields
    localparam int CTL_DUTY_LSB = 4;
    localparam logic [7:0] CTL_WMASK = 8'h3f;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // time base control fields
    localparam int TBC_RUN = 0;
    localparam int TBC_ASYNC = 1;
    // flag and enable register fields
    localparam int FLG_OVF = 0;
    localparam int FLG_CH = 1;
    // interrupt control fields
    localparam int INT_PERIPHERAL_INTERRUPT_ENABLE = 6;
    localparam int INT_GIE = 7;
    // mode field codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
    localparam logic [3:0] MODE_CMP_SEV = 4'hb;
    // time base limits
    localparam logic [15:0] TB_MAX = 16'hffff;
    localparam logic [15:0] TB_ZERO = 16'h0000;
    // capture prescale terminal counts
    localparam logic [3:0] PRE_DIV4_LAST = 4'h3;
    localparam logic [3:0] PRE_DIV16_LAST = 4'hf;
    // interrupt vector shown when a wake branches
    localparam logic [15:0] IRQ_VECTOR = 16'h0004;
endpackage
